// ### sdmi_core.sv
// shared display memory interface: arbiter, window access and page clearing
module sdmi_core #(
   parameter int DISP_BYTES  = sdmi_pkg::DISP_BYTES,
   parameter int REFRESH_CYC = sdmi_pkg::REFRESH_CYC
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   // window registers
   input  wire logic [1:0]  sfrSel,
   input  wire logic        sfrWr,
   input  wire logic        sfrRd,
   input  wire logic [7:0]  sfrWdata,
   output      logic [7:0]  sfrRdata,
   output      logic        sfrReady,
   // direct data moves
   input  wire logic [15:0] xAddr,
   input  wire logic        xWr,
   input  wire logic        xRd,
   input  wire logic [7:0]  xWdata,
   output      logic [7:0]  xRdata,
   output      logic        xReady,
   // display reader
   input  wire logic        dispReq,
   input  wire logic [14:0] dispAddr,
   output      logic [7:0]  dispData,
   // capture writes and clear triggers
   input  wire logic        capWr,
   input  wire logic [14:0] capAddr,
   input  wire logic [7:0]  capData,
   output      logic        capReady,
   input  wire logic        capClr,
   input  wire logic [3:0]  capClrBlock,
   input  wire logic [3:0]  capExtBlock,
   input  wire logic [4:0]  capX27Row,
   input  wire logic        lineStart,
   // configuration and status
   input  wire logic        packet24RowPlacement,
   input  wire logic        inverseDisplayEnable,
   output      logic        clearInProgressFlag
);
   if (DISP_BYTES < 1 || DISP_BYTES > sdmi_pkg::DISP_BYTES) begin : g_chk_disp
      $error("DISP_BYTES out of range");
   end
   if (REFRESH_CYC < 2 || REFRESH_CYC > 1023) begin : g_chk_ref
      $error("REFRESH_CYC out of range");
   end

   localparam logic [13:0] INIT_LAST = 14'(DISP_BYTES - 1);
   localparam logic [9:0]  REF_LAST  = 10'(REFRESH_CYC - 1);

   // aux area has no reset contents and is never touched by clearing
   logic [7:0] mem [sdmi_pkg::MEM_BYTES];

   sdmi_pkg::sdmi_state_t state_q;
   logic [13:0] lin_q;
   logic [1:0]  seg_q;
   logic [4:0]  cRow_q;
   logic [5:0]  cCol_q;
   logic [3:0]  clrBlk_q, clrExt_q, pBlk_q, pExt_q;
   logic [4:0]  x27Row_q, pRow_q;
   logic        capPend_q, swPend_q, lineUsed_q, flag_q;
   logic [4:0]  row_q;
   logic [5:0]  col_q;
   logic [3:0]  page_q;
   logic [9:0]  refCnt_q;
   logic        refDue_q;
   logic [7:0]  sfrRdata_q, xRdata_q, dispData_q;

   function automatic logic [9:0] cellOff(input logic [4:0] r, input logic [5:0] c);
      if (c < sdmi_pkg::COL_SPLIT) return {r, c[4:0]};
      return sdmi_pkg::HI_BASE - {2'h0, r, 3'h0} + {7'h00, c[2:0]};
   endfunction

   function automatic logic [14:0] blkBase(input logic [3:0] b);
      return sdmi_pkg::DISP_BASE + {1'b0, b, 10'h000};
   endfunction

   // window position and stepping
   wire        atEnd   = (row_q == sdmi_pkg::ROW_WRAP) && (col_q == sdmi_pkg::COL_WRAP);
   wire        atLast  = (col_q == sdmi_pkg::COL_LAST);
   wire [4:0]  rowNext = atEnd ? 5'h00 : (atLast ? row_q + 5'h01 : row_q);
   wire [5:0]  colNext = (atEnd || atLast) ? 6'h00 : col_q + 6'h01;
   wire [14:0] winAddr = blkBase(page_q) + {5'h00, cellOff(row_q, col_q)};

   // clear engine addressing
   wire        clrActive = (state_q != sdmi_pkg::ST_IDLE);
   wire [3:0]  segBlk = (seg_q == sdmi_pkg::SEG_ROWS) ? clrBlk_q :
                        (seg_q == sdmi_pkg::SEG_X24 && packet24RowPlacement) ? clrBlk_q : clrExt_q;
   wire [4:0]  segRow = (seg_q == sdmi_pkg::SEG_ROWS) ? cRow_q :
                        (seg_q == sdmi_pkg::SEG_X24) ?
                        (packet24RowPlacement ? sdmi_pkg::ROW_X24 : sdmi_pkg::ROW_X0) : x27Row_q;
   wire [14:0] clrAddr = (state_q == sdmi_pkg::ST_INIT) ? sdmi_pkg::DISP_BASE + {1'b0, lin_q} :
                         (state_q == sdmi_pkg::ST_SW) ? blkBase(clrBlk_q) + {5'h00, lin_q[9:0]} :
                         blkBase(segBlk) + {5'h00, cellOff(segRow, cCol_q)};
   wire [3:0]  fillBlk = (state_q == sdmi_pkg::ST_SW) ? clrBlk_q : segBlk;
   wire        invFill = (state_q != sdmi_pkg::ST_INIT) && (fillBlk == sdmi_pkg::INV_BLOCK)
                         && inverseDisplayEnable;
   wire [7:0]  clrData = invFill ? sdmi_pkg::INV_FILL : sdmi_pkg::SPACE_CODE;

   // arbitration: display, then clearing, then capture, then refresh, then cpu
   wire winAcc   = (sfrSel == sdmi_pkg::REG_DATA) && (sfrWr || sfrRd);
   wire xAcc     = xWr || xRd;
   wire xDec     = (xAddr <= sdmi_pkg::DISP_LAST);
   wire clrGnt   = clrActive && !dispReq;
   wire capGnt   = capWr && !dispReq && !clrActive;
   wire refGnt   = refDue_q && !dispReq && !clrActive && !capWr;
   wire cpuFree  = !dispReq && !clrActive && !capWr && !refDue_q;
   wire winGnt   = winAcc && cpuFree;
   wire xMemGnt  = xAcc && xDec && cpuFree && !winAcc;

   sdmi_pkg::sdmi_mreq_t mreq;
   assign mreq = dispReq ? {1'b0, dispAddr, 8'h00} :
                 clrActive ? {1'b1, clrAddr, clrData} :
                 capWr ? {1'b1, capAddr, capData} :
                 winGnt ? {sfrWr, winAddr, sfrWdata} :
                 xMemGnt ? {xWr, xAddr[14:0], xWdata} :
                 {1'b0, 15'h0000, 8'h00};
   wire       memOk  = (mreq.addr <= sdmi_pkg::MEM_LAST);
   wire [7:0] memOut = memOk ? mem[mreq.addr] : 8'h00;

   assign sfrReady = !winAcc || cpuFree;
   assign xReady   = !xAcc || !xDec || (cpuFree && !winAcc);
   assign capReady = !dispReq && !clrActive;
   assign sfrRdata = sfrRdata_q;
   assign xRdata   = xRdata_q;
   assign dispData = dispData_q;
   assign clearInProgressFlag = flag_q;

   // clear scheduling
   wire swReqWr  = sfrWr && (sfrSel == sdmi_pkg::REG_ROW) && sfrWdata[sdmi_pkg::CLR_BIT];
   wire capGo    = capPend_q && !lineUsed_q;
   wire capStart = capGo && (state_q == sdmi_pkg::ST_IDLE || state_q == sdmi_pkg::ST_SW);
   wire swStart  = swPend_q && lineStart && !capPend_q && !capClr
                   && (state_q == sdmi_pkg::ST_IDLE);
   wire linEnd   = (lin_q[9:0] == sdmi_pkg::BLK_LAST);
   wire swDone   = (state_q == sdmi_pkg::ST_SW) && !capGo && clrGnt && linEnd;
   wire initDone = (state_q == sdmi_pkg::ST_INIT) && clrGnt && (lin_q == INIT_LAST);
   wire colEnd   = (cCol_q == sdmi_pkg::COL_LAST);
   wire capDone  = (state_q == sdmi_pkg::ST_CAP) && clrGnt && colEnd
                   && (seg_q == sdmi_pkg::SEG_X27);

   // memory array; writes only inside the mapped range
   always_ff @(posedge clk_sys) begin
      if (mreq.we && memOk) mem[mreq.addr] <= mreq.data;
   end

   // clear sequencer
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state_q <= sdmi_pkg::ST_INIT;
         lin_q   <= 14'h0000;
         seg_q   <= sdmi_pkg::SEG_ROWS;
         cRow_q  <= sdmi_pkg::ROW_CLR_1ST;
         cCol_q  <= 6'h00;
      end else begin
         case (state_q)
            sdmi_pkg::ST_INIT: begin
               if (clrGnt) lin_q <= lin_q + 14'h0001;
               if (initDone) state_q <= sdmi_pkg::ST_IDLE;
            end
            sdmi_pkg::ST_IDLE: begin
               if (capStart) begin
                  state_q <= sdmi_pkg::ST_CAP;
                  seg_q   <= sdmi_pkg::SEG_ROWS;
                  cRow_q  <= sdmi_pkg::ROW_CLR_1ST;
                  cCol_q  <= 6'h00;
               end else if (swStart) begin
                  state_q <= sdmi_pkg::ST_SW;
                  lin_q   <= 14'h0000;
               end
            end
            sdmi_pkg::ST_SW: begin
               if (capStart) begin
                  // capture wins the line; the software clear restarts later
                  state_q <= sdmi_pkg::ST_CAP;
                  seg_q   <= sdmi_pkg::SEG_ROWS;
                  cRow_q  <= sdmi_pkg::ROW_CLR_1ST;
                  cCol_q  <= 6'h00;
               end else if (clrGnt) begin
                  lin_q <= lin_q + 14'h0001;
                  if (linEnd) state_q <= sdmi_pkg::ST_IDLE;
               end
            end
            sdmi_pkg::ST_CAP: begin
               if (clrGnt) begin
                  cCol_q <= colEnd ? 6'h00 : cCol_q + 6'h01;
                  if (colEnd) begin
                     if (seg_q == sdmi_pkg::SEG_ROWS && cRow_q != sdmi_pkg::ROW_CLR_END)
                        cRow_q <= cRow_q + 5'h01;
                     else if (seg_q == sdmi_pkg::SEG_ROWS)
                        seg_q <= sdmi_pkg::SEG_X24;
                     else if (seg_q == sdmi_pkg::SEG_X24)
                        seg_q <= sdmi_pkg::SEG_X27;
                     else
                        state_q <= sdmi_pkg::ST_IDLE;
                  end
               end
            end
            default: state_q <= sdmi_pkg::ST_IDLE;
         endcase
      end
   end

   // capture trigger latch; blocks copied when the clear begins
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         capPend_q <= 1'b0;
         pBlk_q    <= 4'h0;
         pExt_q    <= 4'h0;
         pRow_q    <= 5'h00;
         clrBlk_q  <= 4'h0;
         clrExt_q  <= 4'h0;
         x27Row_q  <= 5'h00;
      end else begin
         capPend_q <= capClr || (capPend_q && !capStart);
         if (capClr) begin
            pBlk_q <= capClrBlock;
            pExt_q <= capExtBlock;
            pRow_q <= capX27Row;
         end
         if (capStart) begin
            clrBlk_q <= pBlk_q;
            clrExt_q <= pExt_q;
            x27Row_q <= pRow_q;
         end else if (swStart) begin
            clrBlk_q <= page_q;
         end
      end
   end

   // line budget, software request and busy flag; a new request beats completion
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         lineUsed_q <= 1'b0;
         swPend_q   <= 1'b0;
         flag_q     <= 1'b1;
      end else begin
         lineUsed_q <= capStart || swStart || (lineUsed_q && !lineStart);
         swPend_q   <= swReqWr || (swPend_q && !swDone);
         flag_q     <= swReqWr || (swPend_q && !swDone)
                       || (state_q == sdmi_pkg::ST_INIT && !initDone);
      end
   end

   // window registers; the clear bit is a strobe and reads back as zero
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         row_q  <= 5'h00;
         col_q  <= 6'h00;
         page_q <= 4'h0;
      end else begin
         if (sfrWr && sfrSel == sdmi_pkg::REG_ROW) row_q <= sfrWdata[4:0];
         if (sfrWr && sfrSel == sdmi_pkg::REG_COL) col_q <= sfrWdata[5:0];
         if (sfrWr && sfrSel == sdmi_pkg::REG_PAGE) page_q <= sfrWdata[3:0];
         if (winGnt) begin
            row_q <= rowNext;
            col_q <= colNext;
         end
      end
   end

   // read data
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         sfrRdata_q <= 8'h00;
         xRdata_q   <= 8'h00;
         dispData_q <= 8'h00;
      end else begin
         if (dispReq) dispData_q <= memOut;
         if (xRd && xMemGnt) xRdata_q <= memOut;
         else if (xRd && !xDec) xRdata_q <= 8'h00;
         if (sfrRd && sfrSel == sdmi_pkg::REG_ROW) sfrRdata_q <= {3'h0, row_q};
         if (sfrRd && sfrSel == sdmi_pkg::REG_COL) sfrRdata_q <= {2'h0, col_q};
         if (sfrRd && sfrSel == sdmi_pkg::REG_PAGE) sfrRdata_q <= {4'h0, page_q};
         if (sfrRd && winGnt) sfrRdata_q <= memOut;
      end
   end

   // refresh: a due slot holds the cpu off until taken
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         refCnt_q <= 10'h000;
         refDue_q <= 1'b0;
      end else begin
         refCnt_q <= (refCnt_q == REF_LAST) ? 10'h000 : refCnt_q + 10'h001;
         refDue_q <= (refCnt_q == REF_LAST) || (refDue_q && !refGnt);
      end
   end

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence sSwReq;
      sfrWr && sfrSel == sdmi_pkg::REG_ROW && sfrWdata[sdmi_pkg::CLR_BIT];
   endsequence

   sequence sWinStep;
      winGnt && !atEnd;
   endsequence

   a_display_first: assert property (dispReq |-> !winGnt && !xMemGnt && !capGnt && !clrGnt)
      else $error("display request not served first");

   a_column_wrap: assert property (sWinStep and atLast |=> col_q == 6'h00 && row_q == $past(row_q) + 5'h01)
      else $error("column wrap did not advance row");

   a_window_end: assert property (winGnt && atEnd |=> row_q == 5'h00 && col_q == 6'h00)
      else $error("row and column not zeroed at end");

   a_window_step: assert property (sWinStep and !atLast |=> col_q == $past(col_q) + 6'h01 && row_q == $past(row_q))
      else $error("data access did not advance column");

   a_busy_on_req: assert property (sSwReq |=> clearInProgressFlag [*2])
      else $error("busy flag not raised by clear request");

   a_one_per_line: assert property (capStart || swStart |-> !lineUsed_q || lineStart)
      else $error("second page clear in one line");

   a_inverse_fill: assert property (clrGnt && invFill |-> mreq.we && mreq.data == sdmi_pkg::INV_FILL)
      else $error("inverse block 8 not cleared to 00H");

   a_space_fill: assert property (clrGnt && !invFill |-> mreq.we && mreq.data == sdmi_pkg::SPACE_CODE)
      else $error("clear did not write space code");

   a_unmapped_move: assert property (xWr && !xDec |-> xReady && !(mreq.we && mreq.addr == xAddr[14:0] && !clrActive && !capWr))
      else $error("move above display RAM reached memory");

   a_cap_clear_len: assert property (capStart && !dispReq |=> (state_q == sdmi_pkg::ST_CAP) [*8])
      else $error("capture clear ended early");

   sequence sCapEnd;
      capDone;
   endsequence

   a_cap_to_idle: assert property (sCapEnd |=> state_q == sdmi_pkg::ST_IDLE)
      else $error("capture clear did not return to idle");

   a_flag_drop: assert property (swDone && !swReqWr |=> !clearInProgressFlag)
      else $error("busy flag stuck after clear");

endmodule // sdmi_core

// ### sdmi_pkg.sv
// constants, types and field layout for the shared display memory interface
// How it works
// - one embedded DRAM shared by capture, display reader and cpu, with refresh slots
// - auxiliary RAM has no reset contents and is kept while idle
// - power-up fills every display RAM byte with 20H; idle keeps contents
// - idle exit by interrupt keeps display RAM; exit by reset refills 20H
// - auxiliary RAM decodes data addresses 0000H to 1FFFH
// - display RAM decodes 2000H to 47FFH and may serve as extra aux RAM
// - display RAM reachable by direct data moves and by window registers
// - pages are 40x25 in 1K blocks, up to ten, chosen by 4-bit select
// - 5-bit row and 6-bit column pick one byte, moved via data port
// - every data port read or write advances row and column
// - column counts to 39, then wraps to 0 and row increments
// - at row 25 column 23 both indices return to zero
// - offset is row*32+col below col 32, else 3F8H-8*row+(col-32)
// - power-on and reset clear whole page memory with busy flag set
// - capture header clear writes 20H to rows 1-23, packet 27 and 24 rows
// - packet 24 row is basic row 24 if placement set, else extension row 0
// - capture clear completes within the TV line of its header
// - writing clear request clears selected block to 20H; bit not held
// - one clear per TV line; software clear waits for a free line
// - busy flag sets on clear request write, drops when clear completes
// - with inverse display on, clearing block 8 writes 00H
package sdmi_pkg;
   localparam int          CLK_MHZ     = 40;
   localparam int          REFRESH_NS  = 15600;
   localparam int          REFRESH_CYC = (REFRESH_NS * CLK_MHZ) / 1000;
   localparam int          DISP_BYTES  = 10240;
   localparam int          MEM_BYTES   = 18432;
   localparam logic [15:0] DISP_LAST   = 16'h47ff;
   localparam logic [14:0] DISP_BASE   = 15'h2000;
   localparam logic [14:0] MEM_LAST    = 15'h47ff;
   localparam logic [7:0]  SPACE_CODE  = 8'h20;
   localparam logic [7:0]  INV_FILL    = 8'h00;
   localparam logic [3:0]  INV_BLOCK   = 4'h8;
   localparam logic [4:0]  ROW_WRAP    = 5'h19;
   localparam logic [5:0]  COL_WRAP    = 6'h17;
   localparam logic [5:0]  COL_LAST    = 6'h27;
   localparam logic [5:0]  COL_SPLIT   = 6'h20;
   localparam logic [4:0]  ROW_CLR_1ST = 5'h01;
   localparam logic [4:0]  ROW_CLR_END = 5'h17;
   localparam logic [4:0]  ROW_X24     = 5'h18;
   localparam logic [4:0]  ROW_X0      = 5'h00;
   localparam logic [9:0]  HI_BASE     = 10'h3f8;
   localparam logic [9:0]  BLK_LAST    = 10'h3ff;
   // window register select codes
   localparam logic [1:0]  REG_ROW     = 2'h0;
   localparam logic [1:0]  REG_COL     = 2'h1;
   localparam logic [1:0]  REG_DATA    = 2'h2;
   localparam logic [1:0]  REG_PAGE    = 2'h3;
   localparam int          CLR_BIT     = 7;
   // capture clear segments
   localparam logic [1:0]  SEG_ROWS    = 2'h0;
   localparam logic [1:0]  SEG_X24     = 2'h1;
   localparam logic [1:0]  SEG_X27     = 2'h2;

   typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_CAP, ST_SW} sdmi_state_t;

   typedef struct packed {
      logic        we;
      logic [14:0] addr;
      logic [7:0]  data;
   } sdmi_mreq_t;
endpackage

// ### sdmi_far_end.sv
// far-side model: tv line timing and a display reader that steals memory cycles
module sdmi_far_end #(
   parameter int LINE_CYC = 2560
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   // bench control
   input  wire logic        dispOn,
   input  wire logic        dispLow,
   // line timing and display fetches
   output      logic        lineStart,
   output      logic        dispReq,
   output      logic [14:0] dispAddr
);
   timeunit 1ns;
   timeprecision 100ps;

   int lineCnt;

   always @(posedge clk_sys) begin
      if (!nrst) begin
         lineCnt   <= 0;
         lineStart <= 1'b0;
         dispReq   <= 1'b0;
         dispAddr  <= 15'h0000;
      end else begin
         lineCnt   <= (lineCnt == LINE_CYC - 1) ? 0 : lineCnt + 1;
         lineStart <= (lineCnt == LINE_CYC - 1);
         // random fetches make the cpu and clear paths stall at awkward moments
         dispReq   <= dispOn && ($urandom_range(3) == 0);
         // address keeps moving when idle so a stale value never looks valid
         // a narrow range lets the bench aim fetches at bytes of known contents
         dispAddr  <= 15'h2000 + 15'($urandom_range(dispLow ? 63 : 10239));
      end
   end
endmodule // sdmi_far_end

// ### testbench.sv
// self-checking bench for the shared display memory interface
module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk_sys = 1'b0;
   logic        nrst, sfrWr, sfrRd, xWr, xRd, capWr, capClr, dispOn;
   logic [1:0]  sfrSel;
   logic [7:0]  sfrWdata, sfrRdata, xWdata, xRdata, capData, dispData;
   logic [15:0] xAddr;
   logic [14:0] capAddr, dispAddr;
   logic [3:0]  capClrBlock, capExtBlock;
   logic [4:0]  capX27Row;
   logic        sfrReady, xReady, capReady, lineStart, dispReq, clearInProgressFlag;
   logic        packet24RowPlacement, inverseDisplayEnable;
   logic        xTook = 1'b0, sTook = 1'b0, dTook = 1'b0;
   logic        dChk, dispLow;
   logic [7:0]  r [8];
   logic [7:0]  expQ [$];
   int          compares = 0, miscompares = 0, cycles = 0;

   always #12.5 clk_sys = ~clk_sys;

   sdmi_core #(.DISP_BYTES(64), .REFRESH_CYC(16)) u_dut (
      .clk_sys(clk_sys), .nrst(nrst), .sfrSel(sfrSel), .sfrWr(sfrWr), .sfrRd(sfrRd),
      .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .sfrReady(sfrReady), .xAddr(xAddr), .xWr(xWr),
      .xRd(xRd), .xWdata(xWdata), .xRdata(xRdata), .xReady(xReady), .dispReq(dispReq),
      .dispAddr(dispAddr), .dispData(dispData), .capWr(capWr), .capAddr(capAddr), .capData(capData),
      .capReady(capReady), .capClr(capClr), .capClrBlock(capClrBlock), .capExtBlock(capExtBlock),
      .capX27Row(capX27Row), .lineStart(lineStart), .packet24RowPlacement(packet24RowPlacement),
      .inverseDisplayEnable(inverseDisplayEnable), .clearInProgressFlag(clearInProgressFlag));

   sdmi_far_end #(.LINE_CYC(2560)) u_far (
      .clk_sys(clk_sys), .nrst(nrst), .dispOn(dispOn), .dispLow(dispLow), .lineStart(lineStart),
      .dispReq(dispReq), .dispAddr(dispAddr));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task end_of_test;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // read data is taken one cycle after the accepting edge
   always @(posedge clk_sys) begin
      cycles++;
      if (xTook || sTook) check(xTook ? xRdata : sfrRdata, expQ.pop_front());
      if (dTook) check(dispData, sdmi_pkg::SPACE_CODE);
      xTook <= xRd && xReady;
      sTook <= sfrRd && sfrReady;
      // fetches inside the freshly filled bytes must return the fill value
      dTook <= dChk && dispReq && dispAddr < 15'h2040;
      if (cycles == 40000) begin
         miscompares++;
         end_of_test();
      end
   end

   function automatic logic [15:0] adr(input int blk, input int row, input int col);
      adr = 16'h2000 + 16'(blk * 1024) + 16'(col < 32 ? row * 32 + col : 1016 - 8 * row + col - 32);
   endfunction

   task automatic hold(input int lim);
      int n;
      n = 0;
      @(negedge clk_sys);
      while (!(capWr ? capReady : (xReady && sfrReady)) && n < lim) begin
         n++;
         @(negedge clk_sys);
      end
      if (n >= lim) check(8'h01, 8'h00);
      @(posedge clk_sys);
   endtask

   task automatic xop(input logic wr, input logic [15:0] a, input logic [7:0] d);
      xAddr  <= a;
      xWr    <= wr;
      xRd    <= ~wr;
      xWdata <= d;
      hold(4000);
      xWr <= 1'b0;
      xRd <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic sop(input logic wr, input logic [1:0] sel, input logic [7:0] d);
      sfrSel   <= sel;
      sfrWr    <= wr;
      sfrRd    <= ~wr;
      sfrWdata <= d;
      hold(4000);
      sfrWr <= 1'b0;
      sfrRd <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic xrd(input logic [15:0] a, input logic [7:0] e);
      expQ.push_back(e);
      xop(1'b0, a, 8'h00);
   endtask

   task automatic srd(input logic [7:0] e);
      expQ.push_back(e);
      sop(1'b0, sdmi_pkg::REG_DATA, 8'h00);
   endtask

   task automatic setpos(input logic [3:0] blk, input logic [4:0] row, input logic [5:0] col);
      sop(1'b1, sdmi_pkg::REG_PAGE, {4'h0, blk});
      sop(1'b1, sdmi_pkg::REG_ROW, {3'h0, row});
      sop(1'b1, sdmi_pkg::REG_COL, {2'h0, col});
   endtask

   task automatic waitclr;
      int n;
      n = 0;
      while (clearInProgressFlag !== 1'b0 && n < 8000) begin
         n++;
         @(posedge clk_sys);
      end
      check({7'h00, clearInProgressFlag}, 8'h00);
   endtask

   task automatic doreset;
      nrst <= 1'b0;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      check({7'h00, clearInProgressFlag}, 8'h01);
      waitclr();
   endtask

   initial begin
      {sfrWr, sfrRd, xWr, xRd, capWr, capClr, dispOn, dispLow, dChk} = '0;
      {sfrSel, sfrWdata, xWdata, xAddr, capAddr, capData, capClrBlock, capExtBlock, capX27Row} = '0;
      {packet24RowPlacement, inverseDisplayEnable} = '0;
      nrst = 1'b0;
      void'($urandom(37));
      foreach (r[i]) r[i] = 8'($urandom);
      @(posedge clk_sys);
      doreset();
      dispOn  <= 1'b1;
      // display fetches confined to the filled bytes for a while
      dispLow <= 1'b1;
      dChk    <= 1'b1;
      repeat (100) @(posedge clk_sys);
      dispLow <= 1'b0;
      dChk    <= 1'b0;
      setpos(4'h0, 5'd0, 6'd0);
      srd(8'h20);
      // column wrap at 39 into the next row
      setpos(4'h0, 5'd0, 6'd38);
      for (int i = 0; i < 3; i++) sop(1'b1, sdmi_pkg::REG_DATA, r[i]);
      xrd(adr(0, 0, 38), r[0]);
      xrd(adr(0, 0, 39), r[1]);
      xrd(adr(0, 1, 0), r[2]);
      // last position wraps both indices
      setpos(4'h0, 5'd25, 6'd23);
      sop(1'b1, sdmi_pkg::REG_DATA, r[3]);
      sop(1'b1, sdmi_pkg::REG_DATA, r[4]);
      xrd(adr(0, 25, 23), r[3]);
      xrd(16'h2000, r[4]);
      expQ.push_back(8'h01);
      sop(1'b0, sdmi_pkg::REG_COL, 8'h00);
      // direct write seen through the window
      xop(1'b1, adr(2, 3, 35), r[5]);
      setpos(4'h2, 5'd3, 6'd35);
      srd(r[5]);
      xop(1'b1, 16'h0100, r[6]);
      xrd(16'h0100, r[6]);
      xop(1'b1, 16'h5000, r[7]);
      xrd(16'h5000, 8'h00);
      capWr   <= 1'b1;
      capAddr <= 15'h2a10;
      capData <= r[7];
      hold(4000);
      capWr <= 1'b0;
      @(posedge clk_sys);
      xrd(16'h2a10, r[7]);
      // software clears: plain block, then inverse on block 8
      for (int k = 0; k < 2; k++) begin
         xop(1'b1, adr(k ? 8 : 1, 24, 39), 8'h55);
         inverseDisplayEnable <= (k == 1);
         sop(1'b1, sdmi_pkg::REG_PAGE, k ? 8'h08 : 8'h01);
         sop(1'b1, sdmi_pkg::REG_ROW, 8'h80);
         check({7'h00, clearInProgressFlag}, 8'h01);
         waitclr();
         xrd(adr(k ? 8 : 1, 0, 0), k ? 8'h00 : 8'h20);
         xrd(adr(k ? 8 : 1, 24, 39), k ? 8'h00 : 8'h20);
      end
      inverseDisplayEnable <= 1'b0;
      // capture clear must finish well inside one line
      xop(1'b1, adr(3, 0, 0), 8'h66);
      xop(1'b1, adr(3, 1, 0), 8'h55);
      xop(1'b1, adr(4, 0, 0), 8'h99);
      xop(1'b1, adr(4, 2, 5), 8'h88);
      dispOn <= 1'b0;
      packet24RowPlacement <= 1'b1;
      @(posedge lineStart);
      @(posedge clk_sys);
      capClr      <= 1'b1;
      capClrBlock <= 4'h3;
      capExtBlock <= 4'h4;
      capX27Row   <= 5'd2;
      @(posedge clk_sys);
      capClr <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check({7'h00, capReady}, 8'h00);
      repeat (1100) @(posedge clk_sys);
      check({7'h00, capReady}, 8'h01);
      xrd(adr(3, 1, 0), 8'h20);
      xrd(adr(3, 0, 0), 8'h66);
      xrd(adr(3, 24, 0), 8'h20);
      xrd(adr(4, 2, 5), 8'h20);
      xrd(adr(4, 0, 0), 8'h99);
      // a second reset refills the first 64 display bytes
      doreset();
      xrd(16'h2000, 8'h20);
      repeat (2) @(posedge clk_sys);
      end_of_test();
   end
endmodule // testbench
